// ### tpw_pkg.sv
// constants for the dual-slope timer pwm block
package tpw_pkg;

  // ---------------------------------------------------------------
  // register byte addresses
  // ---------------------------------------------------------------
  localparam logic [7:0] TPW_ADDR_CTRL_A = 8'h24;
  localparam logic [7:0] TPW_ADDR_CTRL_B = 8'h28;
  localparam logic [7:0] TPW_ADDR_CMP_A  = 8'h2c;
  localparam logic [7:0] TPW_ADDR_COUNT  = 8'h30;
  localparam logic [7:0] TPW_ADDR_STATUS = 8'h34;
  localparam logic [7:0] TPW_ADDR_MASK   = 8'h38;
  localparam logic [7:0] TPW_ADDR_PORT   = 8'h3c;

  // ---------------------------------------------------------------
  // field positions and reset values
  // ---------------------------------------------------------------
  localparam int         TPW_OUT_A_HI     = 7;
  localparam int         TPW_OUT_A_LO     = 6;
  localparam int         TPW_OUT_B_HI     = 5;
  localparam int         TPW_OUT_B_LO     = 4;
  localparam int         TPW_WAVE_LOW_HI  = 1;
  localparam int         TPW_WAVE_HIGH    = 3;
  localparam int         TPW_CSEL_HI      = 2;
  localparam int         TPW_ST_OVF       = 0;
  localparam int         TPW_ST_CMPA      = 1;
  localparam int         TPW_PORT_DIR     = 0;
  localparam int         TPW_PORT_DATA    = 1;
  localparam logic [7:0] TPW_CTRL_A_RESET = 8'h00;
  localparam logic [7:0] TPW_CTRL_A_WMASK = 8'hf3;
  localparam logic [7:0] TPW_CTRL_B_WMASK = 8'h0f;
  localparam logic [7:0] TPW_BOTTOM       = 8'h00;
  localparam logic [7:0] TPW_MAX          = 8'hff;

  // ---------------------------------------------------------------
  // prescaler: tick when the low bits of the divider are all ones
  // ---------------------------------------------------------------
  localparam int          TPW_PRESC_W  = 10;
  localparam logic [9:0]  TPW_DIV8_M   = 10'h007;
  localparam logic [9:0]  TPW_DIV64_M  = 10'h03f;
  localparam logic [9:0]  TPW_DIV256_M = 10'h0ff;
  localparam logic [9:0]  TPW_DIV1K_M  = 10'h3ff;

  // ---------------------------------------------------------------
  // waveform modes
  // ---------------------------------------------------------------
  typedef enum logic [2:0] {
    TPW_M_NORMAL  = 3'b000,
    TPW_M_PC_FF   = 3'b001,
    TPW_M_CTC     = 3'b010,
    TPW_M_FAST_FF = 3'b011,
    TPW_M_RES4    = 3'b100,
    TPW_M_PC_CMP  = 3'b101,
    TPW_M_RES6    = 3'b110,
    TPW_M_FAST_CM = 3'b111
  } tpw_mode_t;

endpackage

// ### tpw_timer.sv
// dual-slope timer pwm with output a control and apb registers
//
// Function
// - modes 1 and 5 count up to top then down to bottom, repeating.
// - mode 1 top is 0xff; mode 5 top is the compare a value.
// - non-inverting clears on up match, sets on down match; inverting opposite.
// - count shows top for one tick, then counts down.
// - overflow flag sets each time dual-slope count reaches bottom.
// - output mode 2 is non-inverted pwm, 3 is inverted pwm.
// - output mode 1 in pwm toggles on match only when mode high bit set.
// - nonzero output mode overrides port value, except mode 1 in pwm without high bit; direction bit enables driver.
// - compare bottom gives constant low in mode 1, max constant high (non-inverted).
// - transition at top when the up-count match was missed this period.
// - mode 1 pwm period is 510 ticks; tick rate is clock over 1,8,64,256,1024.
// - everything runs on clk_i; tick is a clock enable only.
// - non-pwm output modes: off, toggle, clear, set on match.
// - single-slope: mode 2 clears on match, sets at bottom; 3 opposite.
// - single-slope with compare equal top: match ignored, action at bottom.
// - dual-slope with compare equal top: match ignored, action at top.
// - control a: out a 7:6, out b 5:4, reserved 3:2 zero, mode 1:0.
// - mode field is control b bit 3 over control a bits 1:0.
`timescale 1ns/1ps
`default_nettype none

module tpw_timer
  import tpw_pkg::*;
(
  input  wire logic        clk_i,
  input  wire logic        rst_n_i,
  input  wire logic        psel_i,
  input  wire logic        penable_i,
  input  wire logic        pwrite_i,
  input  wire logic [7:0]  paddr_i,
  input  wire logic [31:0] pwdata_i,
  output logic [31:0]      prdata_o,
  output logic             pready_o,
  output logic             pslverr_o,
  output logic             irq_o,
  output logic             pin_o,
  output logic             pin_oe_o
);

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  logic [7:0]             ctrl_a;
  logic [7:0]             ctrl_b;
  logic [7:0]             cmp_buf;
  logic [7:0]             cmp_act;
  logic [7:0]             count;
  logic                   down;
  logic                   wave;
  logic                   seen_up;
  logic [1:0]             status;
  logic [1:0]             mask;
  logic [1:0]             port;
  logic [TPW_PRESC_W-1:0] presc;

  logic                   tick;
  logic                   wr_en;
  logic                   rd_en;
  logic                   mapped;
  logic [31:0]            next_rdata;
  tpw_mode_t              mode;
  logic                   dual;
  logic                   fast;
  logic                   pwm;
  logic [7:0]             top;
  logic                   match;
  logic                   at_top;
  logic [1:0]             out_a;
  logic                   connected;
  logic [7:0]             next_count;
  logic                   next_down;
  logic                   next_wave;
  logic                   next_seen;
  logic                   ovf_ev;
  logic                   st_clr;
  logic                   cmp_is_top;

  function automatic logic is_mapped(input logic [7:0] a);
    return a == TPW_ADDR_CTRL_A || a == TPW_ADDR_CTRL_B || a == TPW_ADDR_CMP_A ||
           a == TPW_ADDR_COUNT || a == TPW_ADDR_STATUS || a == TPW_ADDR_MASK ||
           a == TPW_ADDR_PORT;
  endfunction

  // ---------------------------------------------------------------
  // apb slave: one wait-free access phase, answer registered
  // ---------------------------------------------------------------
  assign mapped = is_mapped(paddr_i);
  assign wr_en  = psel_i && penable_i && pready_o && pwrite_i && mapped;
  assign rd_en  = psel_i && penable_i && pready_o && !pwrite_i;

  always_comb begin
    next_rdata = 32'h0000_0000;
    unique case (paddr_i)
      TPW_ADDR_CTRL_A: next_rdata[7:0] = ctrl_a & TPW_CTRL_A_WMASK;
      TPW_ADDR_CTRL_B: next_rdata[7:0] = ctrl_b;
      TPW_ADDR_CMP_A:  next_rdata[7:0] = cmp_buf;
      TPW_ADDR_COUNT:  next_rdata[7:0] = count;
      TPW_ADDR_STATUS: next_rdata[1:0] = status;
      TPW_ADDR_MASK:   next_rdata[1:0] = mask;
      TPW_ADDR_PORT:   next_rdata[1:0] = port;
      default:         next_rdata      = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pready_o  <= 1'b0;
      pslverr_o <= 1'b0;
      prdata_o  <= 32'h0000_0000;
    end else begin
      // data is captured in the setup cycle so it can leave a flop
      pready_o  <= psel_i && !penable_i && !pready_o;
      pslverr_o <= psel_i && !penable_i && !pready_o && !mapped;
      if (psel_i && !penable_i && !pwrite_i) begin
        prdata_o <= next_rdata;
      end
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ctrl_a  <= TPW_CTRL_A_RESET;
      ctrl_b  <= TPW_BOTTOM;
      cmp_buf <= TPW_BOTTOM;
      mask    <= 2'h0;
      port    <= 2'h0;
    end else if (wr_en) begin
      unique case (paddr_i)
        TPW_ADDR_CTRL_A: ctrl_a  <= pwdata_i[7:0] & TPW_CTRL_A_WMASK;
        TPW_ADDR_CTRL_B: ctrl_b  <= pwdata_i[7:0] & TPW_CTRL_B_WMASK;
        TPW_ADDR_CMP_A:  cmp_buf <= pwdata_i[7:0];
        TPW_ADDR_MASK:   mask    <= pwdata_i[1:0];
        TPW_ADDR_PORT:   port    <= pwdata_i[1:0];
        default:         ;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // prescaler tick enable
  // ---------------------------------------------------------------
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      presc <= '0;
    end else begin
      presc <= presc + 1'b1;
    end
  end

  always_comb begin
    unique case (ctrl_b[TPW_CSEL_HI:0])
      3'h1:    tick = 1'b1;
      3'h2:    tick = (presc & TPW_DIV8_M) == TPW_DIV8_M;
      3'h3:    tick = (presc & TPW_DIV64_M) == TPW_DIV64_M;
      3'h4:    tick = (presc & TPW_DIV256_M) == TPW_DIV256_M;
      3'h5:    tick = presc == TPW_DIV1K_M;
      default: tick = 1'b0;
    endcase
  end

  // ---------------------------------------------------------------
  // mode decode
  // ---------------------------------------------------------------
  assign mode   = tpw_mode_t'({ctrl_b[TPW_WAVE_HIGH], ctrl_a[TPW_WAVE_LOW_HI:0]});
  assign dual   = mode == TPW_M_PC_FF || mode == TPW_M_PC_CMP;
  assign fast   = mode == TPW_M_FAST_FF || mode == TPW_M_FAST_CM;
  assign pwm    = dual || fast;
  assign top    = (mode == TPW_M_PC_CMP || mode == TPW_M_FAST_CM || mode == TPW_M_CTC) ?
                  cmp_act : TPW_MAX;
  assign match  = count == cmp_act;
  assign at_top = !down && count >= top;
  assign out_a  = ctrl_a[TPW_OUT_A_HI:TPW_OUT_A_LO];
  assign connected = out_a != 2'b00 && !(pwm && out_a == 2'b01 && !ctrl_b[TPW_WAVE_HIGH]);
  // the compare that is active after this turn decides the top action, so a
  // compare leaving max already takes the up-match level at that turn
  assign cmp_is_top = mode == TPW_M_PC_CMP || cmp_buf == TPW_MAX;

  // ---------------------------------------------------------------
  // counter sequence
  // ---------------------------------------------------------------
  always_comb begin
    next_count = count;
    next_down  = down;
    ovf_ev     = 1'b0;
    if (dual) begin
      if (at_top) begin
        // top shows for this one tick, then we leave it downward
        next_count = (count == TPW_BOTTOM) ? TPW_BOTTOM : count - 8'h01;
        next_down  = count != TPW_BOTTOM;
      end else if (!down) begin
        next_count = count + 8'h01;
      end else if (count <= 8'h01) begin
        next_count = TPW_BOTTOM;
        next_down  = 1'b0;
        ovf_ev     = 1'b1;
      end else begin
        next_count = count - 8'h01;
      end
    end else begin
      next_down  = 1'b0;
      next_count = (count == top) ? TPW_BOTTOM : count + 8'h01;
      ovf_ev     = (mode == TPW_M_FAST_CM) ? count == top : count == TPW_MAX;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      count <= TPW_BOTTOM;
      down  <= 1'b0;
    end else if (wr_en && paddr_i == TPW_ADDR_COUNT) begin
      count <= pwdata_i[7:0];
    end else if (tick) begin
      count <= next_count;
      down  <= next_down;
    end
  end

  // ---------------------------------------------------------------
  // compare double buffer
  // ---------------------------------------------------------------
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cmp_act <= TPW_BOTTOM;
    end else if (!pwm) begin
      cmp_act <= (wr_en && paddr_i == TPW_ADDR_CMP_A) ? pwdata_i[7:0] : cmp_buf;
    end else if (tick && ((dual && at_top) || (fast && count == top))) begin
      cmp_act <= cmp_buf;
    end
  end

  // ---------------------------------------------------------------
  // waveform output a
  // ---------------------------------------------------------------
  always_comb begin
    next_wave = wave;
    next_seen = seen_up;
    if (dual && out_a[1]) begin
      // out_a[0] is the level an up-count match leaves
      if (match && cmp_act != top) begin
        next_wave = down ? ~out_a[0] : out_a[0];
        next_seen = next_seen | !down;
      end
      if (at_top) begin
        if (cmp_is_top) begin
          next_wave = ~out_a[0];
        end else if (!seen_up) begin
          next_wave = out_a[0];
        end
      end
      if (down && count <= 8'h01) begin
        next_seen = 1'b0;
      end
    end else if (fast && out_a[1]) begin
      if (count == top) begin
        next_wave = ~out_a[0];
      end else if (match) begin
        next_wave = out_a[0];
      end
    end else if (out_a == 2'b01 && (!pwm || ctrl_b[TPW_WAVE_HIGH])) begin
      next_wave = match ? ~wave : wave;
    end else if (!pwm && out_a[1] && match) begin
      next_wave = out_a[0];
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      wave    <= 1'b0;
      seen_up <= 1'b0;
    end else if (tick) begin
      wave    <= next_wave;
      seen_up <= next_seen;
    end
  end

  // port override happens only when the output unit is connected
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pin_o    <= 1'b0;
      pin_oe_o <= 1'b0;
    end else begin
      pin_o    <= connected ? wave : port[TPW_PORT_DATA];
      pin_oe_o <= port[TPW_PORT_DIR];
    end
  end

  // ---------------------------------------------------------------
  // interrupt status, cleared by reading it; a new event wins
  // ---------------------------------------------------------------
  // only the bits that the read returned are cleared: an event that lands
  // between setup and access is not in the read data and must survive
  assign st_clr = rd_en && paddr_i == TPW_ADDR_STATUS;

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      status <= 2'h0;
      irq_o  <= 1'b0;
    end else begin
      status[TPW_ST_OVF]  <= (tick && ovf_ev) ||
                             (status[TPW_ST_OVF] && !(st_clr && prdata_o[TPW_ST_OVF]));
      status[TPW_ST_CMPA] <= (tick && match) ||
                             (status[TPW_ST_CMPA] && !(st_clr && prdata_o[TPW_ST_CMPA]));
      irq_o               <= |(status & mask);
    end
  end

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);

  sequence seq_turn_top;
    dual && tick && at_top && count != TPW_BOTTOM && !wr_en;
  endsequence

  sequence seq_leave_top;
    down && count == $past(count) - 8'h01;
  endsequence

  chk_top_hold: assert property (seq_turn_top |=> seq_leave_top)
    else $error("count did not turn down after top");
  chk_ovf_bottom: assert property (dual && tick && down && count == 8'h01 && !wr_en
    |=> count == TPW_BOTTOM && status[TPW_ST_OVF])
    else $error("overflow flag missed at bottom");
  chk_up_clear: assert property (dual && tick && !down && out_a == 2'b10 && match && cmp_act != top
    && !at_top |=> !wave)
    else $error("up match did not clear output");
  chk_down_set: assert property (dual && tick && down && out_a == 2'b10 && match && cmp_act != top
    |=> wave)
    else $error("down match did not set output");
  chk_inv_top: assert property (dual && tick && out_a == 2'b11 && at_top && cmp_act == top
    && cmp_buf == cmp_act |=> !wave)
    else $error("inverted top action wrong");
  chk_mode1_top: assert property (mode == TPW_M_PC_FF |-> top == TPW_MAX)
    else $error("mode 1 top not max");
  chk_tick_gate: assert property (!tick && !$past(wr_en) |=> $stable(count) || $past(wr_en))
    else $error("count moved without tick");
  chk_pin_port: assert property (out_a == 2'b00 |=> pin_o == $past(port[TPW_PORT_DATA]))
    else $error("port value not on pin");
  chk_reserved_zero: assert property (psel_i && !penable_i && !pwrite_i && paddr_i == TPW_ADDR_CTRL_A
    |=> prdata_o[3:2] == 2'b00)
    else $error("reserved bits read nonzero");
  chk_buffer_load: assert property (dual && $past(dual) && pwm && cmp_act != $past(cmp_act)
    |-> $past(tick && at_top))
    else $error("compare loaded away from top");
  chk_toggle_match: assert property (pwm && tick && out_a == 2'b01 && ctrl_b[TPW_WAVE_HIGH] && match
    |=> wave != $past(wave))
    else $error("toggle on match missing");
  chk_miss_up: assert property (dual && tick && at_top && out_a[1] && !wr_en && !seen_up && !cmp_is_top
    |=> wave == $past(out_a[0]))
    else $error("missed up match not restored at top");
  chk_low_bottom: assert property (mode == TPW_M_PC_FF && tick && !down && count == TPW_BOTTOM
    && out_a == 2'b10 && cmp_act == TPW_BOTTOM && !wr_en |=> !wave)
    else $error("bottom compare did not hold output low");

  // ---------------------------------------------------------------
  // interrupt and pin checks
  // ---------------------------------------------------------------
  chk_event_wins: assert property (tick && ovf_ev |=> status[TPW_ST_OVF])
    else $error("overflow event lost");
  chk_irq_follow: assert property ((status & mask) != 2'h0 |=> irq_o)
    else $error("unmasked status did not raise irq");
  chk_irq_quiet: assert property ((status & mask) == 2'h0 |=> !irq_o)
    else $error("irq high without unmasked status");
  chk_pin_drive: assert property (port[TPW_PORT_DIR] |=> pin_oe_o)
    else $error("pin driver not enabled");
  chk_pin_wave: assert property (connected |=> pin_o == $past(wave))
    else $error("waveform not on pin");

endmodule // tpw_timer

`default_nettype wire

// ### tpw_load.sv
// external load model sitting on the waveform pin
`timescale 1ns/1ps
`default_nettype none

module tpw_load (
  input  wire logic clk_i,
  input  wire logic rst_n_i,
  input  wire logic pin_i,
  input  wire logic pin_oe_i,
  output logic      level_o
);
  // ---------------------------------------------------------------
  // line level
  // ---------------------------------------------------------------
  // no pull on this line: a released pin shows the inverse of what was last
  // driven, so a stale value can never pass for a driven one
  logic last_q;

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      last_q <= 1'b0;
    end else if (pin_oe_i) begin
      last_q <= pin_i;
    end
  end

  assign level_o = pin_oe_i ? pin_i : ~last_q;
endmodule // tpw_load

`default_nettype wire

// ### test_timer8_phase_correct_pwm_out.sv
// self-checking testbench for the dual-slope timer pwm block
`timescale 1ns/1ps
`default_nettype none

module test_timer8_phase_correct_pwm_out;
  import tpw_pkg::*;
  // ---------------------------------------------------------------
  // signals
  // ---------------------------------------------------------------
  localparam int LIMIT = 40000;
  logic        clk_i;
  logic        rst_n_i;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        irq;
  logic        pin;
  logic        pin_oe;
  logic        level;
  logic [31:0] r;
  logic        e;
  int          fail_count = 0;
  int          n_compared = 0;
  int          cyc = 0;
  int          hi;
  int          per;
  int          n;
  logic [7:0]  ta [5] = '{8'h81, 8'h81, 8'hc1, 8'hc1, 8'h81};
  logic [7:0]  tb [5] = '{8'h01, 8'h01, 8'h01, 8'h01, 8'h09};
  logic [7:0]  tc [5] = '{8'h00, 8'hff, 8'h00, 8'hff, 8'h20};
  logic        tl [5] = '{1'b0, 1'b1, 1'b1, 1'b0, 1'b1};

  tpw_timer i_tpw_timer (
    .clk_i     (clk_i),
    .rst_n_i   (rst_n_i),
    .psel_i    (psel),
    .penable_i (penable),
    .pwrite_i  (pwrite),
    .paddr_i   (paddr),
    .pwdata_i  (pwdata),
    .prdata_o  (prdata),
    .pready_o  (pready),
    .pslverr_o (pslverr),
    .irq_o     (irq),
    .pin_o     (pin),
    .pin_oe_o  (pin_oe)
  );

  tpw_load i_tpw_load (
    .clk_i    (clk_i),
    .rst_n_i  (rst_n_i),
    .pin_i    (pin),
    .pin_oe_i (pin_oe),
    .level_o  (level)
  );

  initial begin
    clk_i = 1'b0;
    forever #10 clk_i = ~clk_i;
  end

  // ---------------------------------------------------------------
  // tasks
  // ---------------------------------------------------------------
  task summarize;
    if (fail_count == 0 && n_compared > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  task chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp) begin
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
      fail_count++;
    end
  endtask

  task chk_rng(input string nm, input int lo, input int hv, input int got);
    n_compared++;
    if (got < lo || got > hv) begin
      $display("[FAIL] %s expected %0d..%0d seen %0d", nm, lo, hv, got);
      fail_count++;
    end
  endtask

  task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk_i);
    penable <= 1'b1;
    @(posedge clk_i);
    while (pready !== 1'b1) @(posedge clk_i);
    r = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  // timer is stopped while reprogrammed, then left a full period to settle
  task cfg(input logic [7:0] ca, input logic [7:0] cb, input logic [7:0] cmp, input logic [7:0] prt);
    apb(1'b1, TPW_ADDR_CTRL_B, 32'h0);
    apb(1'b1, TPW_ADDR_CMP_A, {24'h0, cmp});
    apb(1'b1, TPW_ADDR_PORT, {24'h0, prt});
    apb(1'b1, TPW_ADDR_COUNT, 32'h0);
    apb(1'b1, TPW_ADDR_CTRL_A, {24'h0, ca});
    apb(1'b1, TPW_ADDR_CTRL_B, {24'h0, cb});
    repeat (600) @(posedge clk_i);
  endtask

  // high time and period of the line, from one rising edge to the next
  task meas;
    @(posedge clk_i);
    while (level !== 1'b0) @(posedge clk_i);
    while (level !== 1'b1) @(posedge clk_i);
    hi = 0;
    while (level === 1'b1) begin
      @(posedge clk_i);
      hi++;
    end
    per = hi;
    while (level !== 1'b1) begin
      @(posedge clk_i);
      per++;
    end
  endtask

  always @(posedge clk_i) begin
    cyc <= cyc + 1;
    if (cyc == LIMIT) begin
      fail_count++;
      summarize();
    end
  end

  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial begin
    rst_n_i = 1'b0;
    psel    = 1'b0;
    penable = 1'b0;
    pwrite  = 1'b0;
    paddr   = 8'h00;
    pwdata  = 32'h0;
    repeat (5) @(posedge clk_i);
    rst_n_i <= 1'b1;
    apb(1'b0, TPW_ADDR_CTRL_A, 32'h0);
    chk("ctrl_a reset", 32'h0, r);
    apb(1'b1, TPW_ADDR_CTRL_A, 32'hff);
    apb(1'b0, TPW_ADDR_CTRL_A, 32'h0);
    chk("ctrl_a reserved", 32'hf3, r);
    apb(1'b0, 8'h40, 32'h0);
    chk("unmapped err", 32'h1, 32'(e));
    chk("unmapped data", 32'h0, r);
    apb(1'b1, TPW_ADDR_CTRL_A, 32'h0);
    apb(1'b1, TPW_ADDR_PORT, 32'h3);
    repeat (3) @(posedge clk_i);
    chk("pin port data", 32'h1, 32'(pin));
    chk("pin drive", 32'h1, 32'(pin_oe));
    apb(1'b1, TPW_ADDR_CTRL_A, 32'h41);
    apb(1'b1, TPW_ADDR_PORT, 32'h3);
    repeat (3) @(posedge clk_i);
    chk("toggle w/o high bit", 32'h1, 32'(pin));
    apb(1'b1, TPW_ADDR_PORT, 32'h0);
    repeat (3) @(posedge clk_i);
    chk("pin released", 32'h0, 32'(pin_oe));
    cfg(8'h81, 8'h01, 8'h40, 8'h01);
    meas();
    chk_rng("pc period", 510, 510, per);
    chk_rng("pc high", 128, 128, hi);
    apb(1'b1, TPW_ADDR_MASK, 32'h1);
    apb(1'b0, TPW_ADDR_STATUS, 32'h0);
    // irq is registered from status, so let the cleared level reach it first
    repeat (2) @(posedge clk_i);
    n = 0;
    while (irq !== 1'b1 && n < 600) begin
      @(posedge clk_i);
      n++;
    end
    chk_rng("overflow wait", 0, 512, n);
    apb(1'b0, TPW_ADDR_STATUS, 32'h0);
    chk("overflow flag", 32'h1, 32'(r[TPW_ST_OVF]));
    repeat (3) @(posedge clk_i);
    chk("irq cleared", 32'h0, 32'(irq));
    apb(1'b1, TPW_ADDR_MASK, 32'h0);
    apb(1'b0, TPW_ADDR_STATUS, 32'h0);
    repeat (600) @(posedge clk_i);
    chk("irq masked", 32'h0, 32'(irq));
    cfg(8'hc1, 8'h01, 8'h40, 8'h01);
    meas();
    chk_rng("pc inv period", 510, 510, per);
    chk_rng("pc inv high", 382, 382, hi);
    cfg(8'h83, 8'h01, 8'h40, 8'h01);
    meas();
    chk_rng("fast period", 256, 256, per);
    chk_rng("fast high", 65, 65, hi);
    cfg(8'h42, 8'h01, 8'h09, 8'h01);
    meas();
    chk_rng("ctc toggle high", 10, 10, hi);
    chk_rng("ctc toggle period", 20, 20, per);
    cfg(8'h41, 8'h09, 8'h20, 8'h01);
    meas();
    chk_rng("top cmp toggle high", 64, 64, hi);
    chk_rng("top cmp toggle period", 128, 128, per);
    for (int i = 0; i < 4; i++) begin
      apb(1'b0, TPW_ADDR_COUNT, 32'h0);
      chk("count within top", 32'h1, 32'(r <= 32'h20));
    end
    for (int i = 0; i < 5; i++) begin
      cfg(ta[i], tb[i], tc[i], 8'h01);
      n = 0;
      repeat (520) begin
        @(posedge clk_i);
        if (level !== tl[i]) n++;
      end
      chk_rng("constant level", 0, 0, n);
    end
    summarize();
  end
endmodule // test_timer8_phase_correct_pwm_out

`default_nettype wire
